// File: inc/irq_ctrl_consts.svh
// register offsets, field positions, reset values and codes of the interrupt controller
// assumes an 8-bit register port with byte offsets
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH
`define PIN_EDGE_OFS      8'hBF
`define IRQ_FLAG_OFS      8'hC8
`define IRQ_ENABLE_OFS    8'hC9
`define STACK_PTR_OFS     8'hDF
`define PIN_EDGE_RST      2'h2
`define STACK_PTR_RST     3'h7
`define IRQ_USED_MASK     8'h75
`define BIT_PIN           0
`define BIT_WAKE          2
`define BIT_TIMER_A       4
`define BIT_TIMER_B       5
`define BIT_USB           6
`define BIT_GIE           7
`define VECTOR_ADDR       16'h0008
`define EDGE_RISE         2'h1
`define EDGE_FALL         2'h2
`define EDGE_BOTH         2'h3
`define FLAGS_KEEP_MASK   8'hF9
`endif

// File: inc/irq_ctrl_pkg.sv
// types of the interrupt controller
// assumes nothing beyond the constants header
package irq_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_SERVE = 2'b10
  } core_state_type;
endpackage

// File: src/irq_ctrl.sv
// interrupt controller: five sources, shared vector, enables, flags, global enable,
// one-level accumulator/flag save buffer, pin edge detect and powerdown wake.
// assumes same-clock event pulses from peripherals and the core, pin from outside.
// Functional notes
// R01: five sources, one external pin
// R02: vector entry clears global enable
// R03: return from irq sets global enable
// R04: entry pushes stack, loads vector eight
// R05: enable register bits, reset zero
// R06: flags set on events, reset zero
// R07: software clears flags, never hardware
// R08: no vector without global enable
// R09: pin edge sets flag regardless enable
// R10: edge select rise fall both encoding
// R11: wake edge latches pin flag, vectors
// R12: timer a overflow sets flag
// R13: one-level save buffer, status bits excluded
// R14: pin event wakes from powerdown
// R15: timer b overflow sets flag
// R16: usb done sets flag
// R17: port wakeup sets wake flag
// R18: request when enabled flag and global
// R19: hardware set beats software clear
// R20: repeated event keeps single flag
`timescale 1ns/1ns
`include "irq_ctrl_consts.svh"
module irq_ctrl
  import irq_ctrl_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_write_i,
  input  wire logic        reg_read_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        external_pin_irq_i,
  input  wire logic        timer_a_ovf_i,
  input  wire logic        timer_b_ovf_i,
  input  wire logic        usb_done_i,
  input  wire logic        port_wakeup_i,
  input  wire logic        irq_accept_i,
  input  wire logic        return_from_irq_i,
  input  wire logic        save_i,
  input  wire logic        restore_i,
  input  wire logic [7:0]  accumulator_i,
  input  wire logic [7:0]  processor_flags_i,
  input  wire logic        powerdown_i,
  output logic             irq_request_o,
  output logic             vector_load_o,
  output logic      [15:0] vector_addr_o,
  output logic      [7:0]  accumulator_o,
  output logic      [7:0]  processor_flags_o,
  output logic             wake_o
);
  logic [1:0]  pin_sync_r;
  logic [1:0]  pin_sync_nxt;
  logic        pin_prev_r;
  logic        pin_prev_nxt;
  logic [1:0]  pin_edge_field_r;
  logic [1:0]  pin_edge_field_nxt;
  logic [7:0]  irq_flag_reg_r;
  logic [7:0]  irq_flag_reg_nxt;
  logic [7:0]  irq_enable_reg_r;
  logic [7:0]  irq_enable_reg_nxt;
  logic        global_irq_enable_r;
  logic        global_irq_enable_nxt;
  logic [2:0]  stack_ptr_r;
  logic [2:0]  stack_ptr_nxt;
  logic [7:0]  acc_save_r;
  logic [7:0]  acc_save_nxt;
  logic [7:0]  flags_save_r;
  logic [7:0]  flags_save_nxt;
  logic [7:0]  reg_rdata_r;
  logic [7:0]  reg_rdata_nxt;
  logic        vector_load_r;
  logic        vector_load_nxt;
  logic        wake_r;
  logic        wake_nxt;
  core_state_type state_r;
  core_state_type state_nxt;
  logic        pin_rise;
  logic        pin_fall;
  logic        pin_event;
  logic [7:0]  hw_set;
  logic        accept;

  assign pin_rise  = pin_sync_r[1] & ~pin_prev_r;
  assign pin_fall  = ~pin_sync_r[1] & pin_prev_r;

  always_comb begin
    pin_event = 1'b0;
    case (pin_edge_field_r) // R10
      `EDGE_RISE: pin_event = pin_rise;
      `EDGE_FALL: pin_event = pin_fall;
      `EDGE_BOTH: pin_event = pin_rise | pin_fall;
      default:    pin_event = 1'b0;
    endcase
  end

  always_comb begin
    hw_set = 8'h00;
    hw_set[`BIT_PIN]     = pin_event; // R01 R09 R11
    hw_set[`BIT_WAKE]    = port_wakeup_i; // R17
    hw_set[`BIT_TIMER_A] = timer_a_ovf_i; // R12
    hw_set[`BIT_TIMER_B] = timer_b_ovf_i; // R15
    hw_set[`BIT_USB]     = usb_done_i; // R16
  end

  // R18 R08
  assign irq_request_o = global_irq_enable_r & (|(irq_flag_reg_r & irq_enable_reg_r));
  assign accept = irq_accept_i & irq_request_o & (state_r == ST_RUN);

  always_comb begin
    pin_sync_nxt          = {pin_sync_r[0], external_pin_irq_i};
    pin_prev_nxt          = pin_sync_r[1];
    pin_edge_field_nxt    = pin_edge_field_r;
    irq_flag_reg_nxt      = irq_flag_reg_r;
    irq_enable_reg_nxt    = irq_enable_reg_r;
    global_irq_enable_nxt = global_irq_enable_r;
    stack_ptr_nxt         = stack_ptr_r;
    acc_save_nxt          = acc_save_r;
    flags_save_nxt        = flags_save_r;
    state_nxt             = state_r;
    vector_load_nxt       = 1'b0;
    wake_nxt              = powerdown_i & pin_event; // R14
    reg_rdata_nxt         = 8'h00;
    if (reg_write_i) begin
      if (reg_addr_i == `PIN_EDGE_OFS) begin
        pin_edge_field_nxt = reg_wdata_i[1:0];
      end else if (reg_addr_i == `IRQ_FLAG_OFS) begin
        irq_flag_reg_nxt = reg_wdata_i & `IRQ_USED_MASK; // R07
      end else if (reg_addr_i == `IRQ_ENABLE_OFS) begin
        irq_enable_reg_nxt = reg_wdata_i & `IRQ_USED_MASK; // R05
      end else if (reg_addr_i == `STACK_PTR_OFS) begin
        global_irq_enable_nxt = reg_wdata_i[`BIT_GIE];
        stack_ptr_nxt         = reg_wdata_i[2:0];
      end
    end
    irq_flag_reg_nxt = irq_flag_reg_nxt | hw_set; // R06 R19 R20
    if (reg_read_i) begin
      if (reg_addr_i == `PIN_EDGE_OFS) begin
        reg_rdata_nxt = {6'h00, pin_edge_field_r};
      end else if (reg_addr_i == `IRQ_FLAG_OFS) begin
        reg_rdata_nxt = irq_flag_reg_r;
      end else if (reg_addr_i == `IRQ_ENABLE_OFS) begin
        reg_rdata_nxt = irq_enable_reg_r;
      end else if (reg_addr_i == `STACK_PTR_OFS) begin
        reg_rdata_nxt = {global_irq_enable_r, 4'h0, stack_ptr_r};
      end else begin
        reg_rdata_nxt = 8'h00;
      end
    end
    case (state_r)
      ST_RUN: begin
        if (accept) begin
          global_irq_enable_nxt = 1'b0; // R02
          stack_ptr_nxt         = stack_ptr_r - 3'h1; // R04
          vector_load_nxt       = 1'b1; // R04
          state_nxt             = ST_SERVE;
        end
      end
      ST_SERVE: begin
        if (return_from_irq_i) begin
          global_irq_enable_nxt = 1'b1; // R03
          stack_ptr_nxt         = stack_ptr_r + 3'h1;
          state_nxt             = ST_RUN;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
    if (save_i) begin
      acc_save_nxt   = accumulator_i; // R13
      flags_save_nxt = processor_flags_i & `FLAGS_KEEP_MASK; // R13
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pin_sync_r          <= 2'h0;
      pin_prev_r          <= 1'b0;
      pin_edge_field_r    <= `PIN_EDGE_RST;
      irq_flag_reg_r      <= 8'h00;
      irq_enable_reg_r    <= 8'h00;
      global_irq_enable_r <= 1'b0;
      stack_ptr_r         <= `STACK_PTR_RST;
      acc_save_r          <= 8'h00;
      flags_save_r        <= 8'h00;
      reg_rdata_r         <= 8'h00;
      vector_load_r       <= 1'b0;
      wake_r              <= 1'b0;
      state_r             <= ST_RUN;
    end else begin
      pin_sync_r          <= pin_sync_nxt;
      pin_prev_r          <= pin_prev_nxt;
      pin_edge_field_r    <= pin_edge_field_nxt;
      irq_flag_reg_r      <= irq_flag_reg_nxt;
      irq_enable_reg_r    <= irq_enable_reg_nxt;
      global_irq_enable_r <= global_irq_enable_nxt;
      stack_ptr_r         <= stack_ptr_nxt;
      acc_save_r          <= acc_save_nxt;
      flags_save_r        <= flags_save_nxt;
      reg_rdata_r         <= reg_rdata_nxt;
      vector_load_r       <= vector_load_nxt;
      wake_r              <= wake_nxt;
      state_r             <= state_nxt;
    end
  end

  assign reg_rdata_o       = reg_rdata_r;
  assign vector_load_o     = vector_load_r;
  assign vector_addr_o     = `VECTOR_ADDR;
  assign accumulator_o     = restore_i ? acc_save_r : accumulator_i;
  assign processor_flags_o = restore_i ? ((processor_flags_i & ~`FLAGS_KEEP_MASK) | flags_save_r)
                                       : processor_flags_i;
  assign wake_o            = wake_r;

  a_entry_clears_gie: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R02
    accept |=> !global_irq_enable_r) else $error("gie not cleared on entry");
  a_return_sets_gie: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R03
    (state_r == ST_SERVE && return_from_irq_i) |=> global_irq_enable_r)
    else $error("gie not set on return");
  a_entry_vector: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R04
    accept |=> vector_load_o && stack_ptr_r == $past(stack_ptr_r) - 3'h1)
    else $error("vector or stack wrong on entry");
  a_no_gie_no_req: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R08
    !global_irq_enable_r |-> !irq_request_o) else $error("request without gie");
  a_set_beats_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R19
    timer_a_ovf_i |=> irq_flag_reg_r[`BIT_TIMER_A]) else $error("timer a event lost");
  a_flag_no_hw_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R07
    (irq_flag_reg_r[`BIT_USB] && !(reg_write_i && reg_addr_i == `IRQ_FLAG_OFS))
    |=> irq_flag_reg_r[`BIT_USB]) else $error("flag cleared by hardware");
  a_pin_flag_set: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R09
    pin_event |=> irq_flag_reg_r[`BIT_PIN]) else $error("pin flag not set");
  a_request_cause: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R18
    irq_request_o |-> |(irq_flag_reg_r & irq_enable_reg_r)) else $error("spurious request");
  a_wake_pin: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R14
    (powerdown_i && pin_event) |=> wake_o) else $error("no wake from pin");
  a_rise_edge: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R10
    (pin_edge_field_r == `EDGE_RISE && pin_fall) |-> !pin_event)
    else $error("falling edge taken in rise mode");
  // edge decode, flag, enable, wake, core handshake and save buffer checks
  a_fall_edge: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R10
    (pin_edge_field_r == `EDGE_FALL && pin_rise) |-> !pin_event)
    else $error("rising edge taken in fall mode");
  a_both_edges: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R10
    (pin_edge_field_r == `EDGE_BOTH && (pin_rise || pin_fall)) |-> pin_event)
    else $error("edge missed in both mode");
  a_reserved_edge: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R10
    (pin_edge_field_r == 2'h0) |-> !pin_event) else $error("event in reserved mode");
  a_wake_latch: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R11
    (powerdown_i && pin_event) |=> irq_flag_reg_r[`BIT_PIN])
    else $error("pin flag not latched on wake");
  a_wake_needs_pd: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R14
    wake_o |-> $past(powerdown_i))
    else $error("wake outside powerdown");
  a_timer_b_flag: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R15
    timer_b_ovf_i |=> irq_flag_reg_r[`BIT_TIMER_B])
    else $error("timer b event lost");
  a_usb_flag: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R16
    usb_done_i |=> irq_flag_reg_r[`BIT_USB])
    else $error("usb event lost");
  a_wakeup_flag: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R17
    port_wakeup_i |=> irq_flag_reg_r[`BIT_WAKE])
    else $error("port wakeup event lost");
  a_clear_race: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R19
    (usb_done_i && reg_write_i && reg_addr_i == `IRQ_FLAG_OFS) |=> irq_flag_reg_r[`BIT_USB])
    else $error("usb event lost to clear");
  a_clear_no_queue: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R20
    (reg_write_i && reg_addr_i == `IRQ_FLAG_OFS && !reg_wdata_i[`BIT_TIMER_A]
     && !timer_a_ovf_i) |=> !irq_flag_reg_r[`BIT_TIMER_A])
    else $error("second timer a request queued");
  a_flags_unused: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R06
    (irq_flag_reg_r & ~`IRQ_USED_MASK) == 8'h00) else $error("unused flag bit set");
  a_enables_unused: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R05
    (irq_enable_reg_r & ~`IRQ_USED_MASK) == 8'h00) else $error("unused enable bit set");
  a_flags_kept_entry: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R07
    (accept && !reg_write_i) |=> irq_flag_reg_r == ($past(irq_flag_reg_r) | $past(hw_set)))
    else $error("flags changed on entry");
  a_vector_needs_gie: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R08
    vector_load_o |-> $past(global_irq_enable_r)) else $error("vector without gie");
  a_vector_needs_enable: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R18
    vector_load_o |-> $past(|(irq_flag_reg_r & irq_enable_reg_r)))
    else $error("vector without enabled flag");
  a_vector_addr: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R04
    vector_load_o |-> vector_addr_o == `VECTOR_ADDR)
    else $error("wrong vector address");
  a_return_pops: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R03
    (state_r == ST_SERVE && return_from_irq_i) |=> stack_ptr_r == $past(stack_ptr_r) + 3'h1)
    else $error("stack not popped on return");
  a_save_masks: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R13
    save_i |=> flags_save_r == ($past(processor_flags_i) & `FLAGS_KEEP_MASK))
    else $error("status bits saved");
  a_restore_acc: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R13
    restore_i |-> accumulator_o == acc_save_r)
    else $error("accumulator not restored");
  c_vector_taken: cover property (@(posedge sys_clk_i) disable iff (reset_i) accept);
  c_return: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    state_r == ST_SERVE && return_from_irq_i);
  c_flag_no_enable: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    irq_flag_reg_r[`BIT_PIN] && !irq_enable_reg_r[`BIT_PIN]);
  c_wake: cover property (@(posedge sys_clk_i) disable iff (reset_i) wake_o);
  c_pin_wake: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    wake_o && irq_flag_reg_r[`BIT_PIN]);
endmodule // irq_ctrl

// File: test/core_model.sv
// processor core stand-in: accepts a pending vector request when armed, counts vector loads
// assumes the same clock and synchronous reset as the interrupt controller
`timescale 1ns/1ns
module core_model (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  input  wire logic       arm_i,
  input  wire logic       irq_request_i,
  input  wire logic       vector_load_i,
  output logic            irq_accept_o,
  output logic      [3:0] loads_o
);
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      irq_accept_o <= 1'b0;
      loads_o      <= 4'h0;
    end else begin
      // one-cycle accept, never two in a row
      irq_accept_o <= arm_i & irq_request_i & ~irq_accept_o;
      loads_o      <= loads_o + 4'(vector_load_i);
    end
  end
endmodule // core_model

// File: test/irq_ctrl_test.sv
// self-checking bench of the interrupt controller: register port tasks and event sequences
// assumes the core model beside it and the constants header on the include path
`timescale 1ns/1ns
`include "irq_ctrl_consts.svh"
module irq_ctrl_test;
  logic        clk = 0, rst = 1, wr_s = 0, rd_s = 0, pin = 0, ret = 0, arm = 0;
  logic        sv = 0, rs = 0, pd = 0, acc_n, req, vld, wk;
  logic [7:0]  adr = 0, wd = 0, rdat, acc = 0, pf = 0, acc_o, pf_o;
  logic [3:0]  ev = 0, loads;
  logic [15:0] vaddr;
  int          fails = 0, comparisons = 0;
  irq_ctrl DUT (.sys_clk_i(clk), .reset_i(rst), .reg_addr_i(adr), .reg_wdata_i(wd),
    .reg_write_i(wr_s), .reg_read_i(rd_s), .reg_rdata_o(rdat), .external_pin_irq_i(pin),
    .timer_a_ovf_i(ev[0]), .timer_b_ovf_i(ev[1]), .usb_done_i(ev[2]), .port_wakeup_i(ev[3]),
    .irq_accept_i(acc_n), .return_from_irq_i(ret), .save_i(sv), .restore_i(rs),
    .accumulator_i(acc), .processor_flags_i(pf), .powerdown_i(pd), .irq_request_o(req),
    .vector_load_o(vld), .vector_addr_o(vaddr), .accumulator_o(acc_o),
    .processor_flags_o(pf_o), .wake_o(wk));
  core_model core (.sys_clk_i(clk), .reset_i(rst), .arm_i(arm), .irq_request_i(req),
    .vector_load_i(vld), .irq_accept_o(acc_n), .loads_o(loads));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) begin adr <= a; wd <= d; wr_s <= 1'b1; end
    @(posedge clk) wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) begin adr <= a; rd_s <= 1'b1; end
    @(posedge clk) rd_s <= 1'b0;
    #1 chk("rdata", {8'h00, e}, {8'h00, rdat});
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge clk) ev <= m;
    @(posedge clk) ev <= 4'h0;
  endtask
  task automatic wrap_up;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    wrap_up;
  end
  initial begin
    logic seen;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(`PIN_EDGE_OFS, 8'h02);
    rd(`IRQ_FLAG_OFS, 8'h00);
    rd(`IRQ_ENABLE_OFS, 8'h00);
    rd(`STACK_PTR_OFS, 8'h07);
    rd(8'h00, 8'h00);
    pulse(4'hF);
    rd(`IRQ_FLAG_OFS, 8'h74);
    #1 chk("req_off", 16'h0, {15'h0, req});
    pulse(4'h1);
    rd(`IRQ_FLAG_OFS, 8'h74);
    wr(`IRQ_FLAG_OFS, 8'h00);
    rd(`IRQ_FLAG_OFS, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(`PIN_EDGE_OFS, 8'(m));
      wr(`IRQ_FLAG_OFS, 8'h00);
      @(posedge clk) pin <= 1'b1;
      repeat (6) @(posedge clk);
      rd(`IRQ_FLAG_OFS, {7'h0, m[0]});
      wr(`IRQ_FLAG_OFS, 8'h00);
      @(posedge clk) pin <= 1'b0;
      repeat (6) @(posedge clk);
      rd(`IRQ_FLAG_OFS, {7'h0, m[1]});
    end
    wr(`IRQ_FLAG_OFS, 8'h00);
    wr(`IRQ_ENABLE_OFS, 8'h10);
    pulse(4'h1);
    #1 chk("req_nogie", 16'h0, {15'h0, req});
    wr(`STACK_PTR_OFS, 8'h87);
    #1 chk("req_on", 16'h1, {15'h0, req});
    @(posedge clk) arm <= 1'b1;
    @(posedge clk) arm <= 1'b0;
    repeat (3) @(posedge clk);
    chk("loads", 16'h1, {12'h0, loads});
    chk("vaddr", `VECTOR_ADDR, vaddr);
    chk("req_srv", 16'h0, {15'h0, req});
    rd(`STACK_PTR_OFS, 8'h06);
    rd(`IRQ_FLAG_OFS, 8'h10);
    @(posedge clk) ret <= 1'b1;
    @(posedge clk) ret <= 1'b0;
    rd(`STACK_PTR_OFS, 8'h87);
    @(posedge clk) begin ev <= 4'h4; adr <= `IRQ_FLAG_OFS; wd <= 8'h00; wr_s <= 1'b1; end
    @(posedge clk) begin ev <= 4'h0; wr_s <= 1'b0; end
    rd(`IRQ_FLAG_OFS, 8'h40);
    @(posedge clk) begin acc <= 8'h5A; pf <= 8'hFF; sv <= 1'b1; end
    @(posedge clk) begin sv <= 1'b0; acc <= 8'h00; pf <= 8'h02; rs <= 1'b1; end
    #1 chk("acc_o", 16'h5A, {8'h00, acc_o});
    chk("pf_o", 16'hFB, {8'h00, pf_o});
    @(posedge clk) begin rs <= 1'b0; pd <= 1'b1; pin <= 1'b1; end
    seen = 1'b0;
    repeat (8) @(posedge clk) seen |= wk;
    chk("wake", 16'h1, {15'h0, seen});
    pd <= 1'b0;
    rd(`IRQ_FLAG_OFS, 8'h41);
    wrap_up;
  end
endmodule // irq_ctrl_test
